// file: logic/frse_encoder.sv
// Top of the floppy result status encoder: flags, bytes and result read-out.
`timescale 1ns/1ps
module frse_encoder
   import frse_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        cmdStart,
   input  wire logic        cmdInvalid,
   input  wire logic        cmdEnd,
   input  wire logic        pollAbort,
   input  wire logic        positionDone,
   input  wire logic        returnsStatus,
   input  wire frse_ctx_t   ctx,
   input  wire frse_event_t evt,
   input  wire logic        trackZeroInput,
   input  wire logic        writeProtectInput,
   input  wire logic        rotationMarkerInput,
   input  wire logic        transferEndStrobe,
   input  wire logic        dataRead,
   output logic [7:0]       dataOut,
   output logic             hostServiceRequest,
   output logic             transferDirection,
   output logic [7:0]       statusFirst,
   output logic [7:0]       statusSecond,
   output logic [7:0]       statusThird
);

   // -----------------------------------------------------------------
   // State and flags
   // -----------------------------------------------------------------
   frse_state_t state_q;
   logic [1:0]  code_q;
   logic        posDone_q;
   logic        relFault_q;
   logic        endTrk_q;
   logic        crcAny_q;
   logic        overrun_q;
   logic        absent_q;
   logic        wprot_q;
   logic        missData_q;
   logic        ctlMark_q;
   logic        crcData_q;
   logic        trkMism_q;
   logic        badTrk_q;
   logic        side_q;
   logic [1:0]  drive_q;
   logic [1:0]  rdIdx_q;
   logic        recalFault;
   logic        idMissing;
   logic        anyError;
   logic        isWrite;
   logic        mismatch;
   logic        endTrkHit;
   logic [7:0]  byteFirst;
   logic [7:0]  byteSecond;
   logic [7:0]  byteThird;

   assign isWrite  = ctx.writeCmd;
   assign mismatch = evt.idTrackValid && (evt.idTrack != ctx.curTrack);
   // A read data or write transfer (not read deleted) that ends without the transfer end strobe ran off the track.
   assign endTrkHit = cmdEnd && (ctx.readData || isWrite) && !transferEndStrobe;

   // -----------------------------------------------------------------
   // Sub-blocks
   // -----------------------------------------------------------------
   frse_step_watch u_step (
      .clk       (clk),
      .reset_n   (reset_n),
      .start     (cmdStart),
      .recal     (ctx.recalibrate),
      .stepPulse (ctx.stepPulse),
      .trackZero (trackZeroInput),
      .fault     (recalFault)
   );

   frse_index_watch u_index (
      .clk        (clk),
      .reset_n    (reset_n),
      .start      (cmdStart),
      .searching  (state_q == FRSE_EXEC && (ctx.readData || ctx.readDeleted || isWrite)),
      .indexPulse (rotationMarkerInput),
      .idMarkSeen (evt.idMarkSeen),
      .missing    (idMissing)
   );

   // -----------------------------------------------------------------
   // Phase sequencing
   // -----------------------------------------------------------------
   // result phase sequencing
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= FRSE_IDLE;
         rdIdx_q <= 2'h0;
      end else begin
         unique case (state_q)
            FRSE_IDLE: begin
               if (cmdStart) begin
                  state_q <= cmdInvalid ? FRSE_RESULT : FRSE_EXEC;
               end
               rdIdx_q <= 2'h0;
            end
            FRSE_EXEC: begin
               if (cmdEnd || pollAbort) begin
                  state_q <= returnsStatus ? FRSE_RESULT : FRSE_DONE;
               end
            end
            FRSE_RESULT: begin
               if (dataRead && hostServiceRequest && transferDirection) begin
                  if (rdIdx_q == 2'h2) begin
                     state_q <= FRSE_DONE;
                  end
                  rdIdx_q <= rdIdx_q + 2'h1;
               end
            end
            FRSE_DONE: begin
               state_q <= FRSE_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Completion code
   // -----------------------------------------------------------------
   // The end-of-track hit is taken directly, since its flag lands on the same edge as the code.
   assign anyError = endTrk_q || endTrkHit || crcAny_q || overrun_q || absent_q || wprot_q
                  || idMissing || missData_q || ctlMark_q || trkMism_q
                  || recalFault || relFault_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         code_q <= FRSE_CC_NORMAL;
      end else if (cmdStart) begin
         code_q <= cmdInvalid ? FRSE_CC_INVALID : FRSE_CC_NORMAL;
      end else if (state_q == FRSE_EXEC && pollAbort) begin
         code_q <= FRSE_CC_POLLING;
      end else if (state_q == FRSE_EXEC && cmdEnd) begin
         code_q <= anyError ? FRSE_CC_ABNORMAL : FRSE_CC_NORMAL;
      end
   end

   // -----------------------------------------------------------------
   // First byte flags
   // -----------------------------------------------------------------
   // positioning and address
   always_ff @(posedge clk) begin
      if (!reset_n || cmdStart) begin
         posDone_q  <= 1'b0;
         relFault_q <= 1'b0;
      end else begin
         if (positionDone) begin
            posDone_q <= 1'b1;
         end
         if (ctx.relSeekOutPastZero) begin
            relFault_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         side_q  <= 1'b0;
         drive_q <= 2'h0;
      end else if (state_q == FRSE_EXEC || cmdStart) begin
         side_q  <= ctx.side;
         drive_q <= ctx.drive;
      end
   end

   // -----------------------------------------------------------------
   // Second and third byte flags
   // -----------------------------------------------------------------
   // Sticky flags; a new command clears them, and the clear wins over a same-cycle
   // event in any state, since cmdStart is not gated on idle here.
   // clear on new command
   always_ff @(posedge clk) begin
      if (!reset_n || cmdStart) begin
         endTrk_q   <= 1'b0;
         crcAny_q   <= 1'b0;
         overrun_q  <= 1'b0;
         absent_q   <= 1'b0;
         wprot_q    <= 1'b0;
         missData_q <= 1'b0;
         ctlMark_q  <= 1'b0;
         crcData_q  <= 1'b0;
         trkMism_q  <= 1'b0;
         badTrk_q   <= 1'b0;
      end else if (state_q == FRSE_EXEC) begin
         if (evt.sectorPastEnd || endTrkHit) begin
            endTrk_q <= 1'b1;
         end
         if (evt.idCrcFault || evt.dataCrcFault) begin
            crcAny_q <= 1'b1;
         end
         if (evt.dataCrcFault) begin
            crcData_q <= 1'b1;
         end
         if (evt.overrun) begin
            overrun_q <= 1'b1;
         end
         if (evt.sectorNotFound || evt.readIdFault || evt.trackSeqFault) begin
            absent_q <= 1'b1;
         end
         if (isWrite && writeProtectInput) begin
            wprot_q <= 1'b1;
         end
         if (evt.dataMarkMissing) begin
            missData_q <= 1'b1;
         end
         if ((ctx.readData && evt.deletedMarkSeen) || (ctx.readDeleted && evt.normalMarkSeen)) begin
            ctlMark_q <= 1'b1;
         end
         if (mismatch) begin
            trkMism_q <= 1'b1;
            if (evt.idTrack == FRSE_BAD_TRACK) begin
               badTrk_q <= 1'b1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Byte assembly
   // -----------------------------------------------------------------
   // byte layout
   always_comb begin
      byteFirst  = {code_q, posDone_q, recalFault || relFault_q, 1'b0, side_q, drive_q};
      byteSecond = FRSE_BYTE_RESET;
      byteSecond[FRSE_B1_END_TRK] = endTrk_q;
      byteSecond[FRSE_B1_CRC_ANY] = crcAny_q;
      byteSecond[FRSE_B1_OVERRUN] = overrun_q;
      byteSecond[FRSE_B1_ABSENT]  = absent_q;
      byteSecond[FRSE_B1_WPROT]   = wprot_q;
      byteSecond[FRSE_B1_MISS_ID] = idMissing || missData_q;
      byteThird  = FRSE_BYTE_RESET;
      byteThird[FRSE_B2_CTL_MARK] = ctlMark_q;
      byteThird[FRSE_B2_CRC_DATA] = crcData_q;
      byteThird[FRSE_B2_TRK_MISM] = trkMism_q;
      byteThird[FRSE_B2_BAD_TRK]  = badTrk_q;
      byteThird[FRSE_B2_MISS_DAT] = missData_q;
   end

   // -----------------------------------------------------------------
   // Registered outputs
   // -----------------------------------------------------------------
   // data register output
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         statusFirst        <= FRSE_BYTE_RESET;
         statusSecond       <= FRSE_BYTE_RESET;
         statusThird        <= FRSE_BYTE_RESET;
         dataOut            <= FRSE_BYTE_RESET;
         hostServiceRequest <= 1'b0;
         transferDirection  <= 1'b0;
      end else begin
         statusFirst        <= byteFirst;
         statusSecond       <= byteSecond;
         statusThird        <= byteThird;
         hostServiceRequest <= state_q == FRSE_IDLE || state_q == FRSE_RESULT;
         transferDirection  <= state_q == FRSE_RESULT;
         unique case (rdIdx_q)
            2'h0:    dataOut <= byteFirst;
            2'h1:    dataOut <= byteSecond;
            default: dataOut <= byteThird;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_invalid_code;
      @(posedge clk) disable iff (!reset_n)
      (state_q == FRSE_IDLE && cmdStart && cmdInvalid) |=> ##1 statusFirst[7:6] == FRSE_CC_INVALID;
   endproperty
   a_invalid_code: assert property (p_invalid_code) else $error("Invalid command code wrong.");

   property p_poll_code;
      @(posedge clk) disable iff (!reset_n)
      (state_q == FRSE_EXEC && pollAbort) |=> ##1 statusFirst[7:6] == FRSE_CC_POLLING;
   endproperty
   a_poll_code: assert property (p_poll_code) else $error("Polling code wrong.");

   property p_end_code;
      @(posedge clk) disable iff (!reset_n)
      (state_q == FRSE_EXEC && cmdEnd && !pollAbort && !cmdStart && endTrkHit)
         |=> ##1 statusFirst[7:6] == FRSE_CC_ABNORMAL && statusSecond[FRSE_B1_END_TRK];
   endproperty
   a_end_code: assert property (p_end_code) else $error("End of track not abnormal.");

   property p_unused_zero;
      @(posedge clk) disable iff (!reset_n)
      !statusFirst[3] && !statusSecond[6] && !statusSecond[3] && statusThird[7] == 1'b0 && statusThird[3:2] == 2'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("Unused bit set.");

   property p_overrun;
      @(posedge clk) disable iff (!reset_n)
      (state_q == FRSE_EXEC && evt.overrun && !cmdStart) |=> ##1 statusSecond[FRSE_B1_OVERRUN];
   endproperty
   a_overrun: assert property (p_overrun) else $error("Overrun not reported.");

   property p_wprot;
      @(posedge clk) disable iff (!reset_n)
      (state_q == FRSE_EXEC && isWrite && writeProtectInput) |=> ##1 statusSecond[FRSE_B1_WPROT];
   endproperty
   a_wprot: assert property (p_wprot) else $error("Write protect not reported.");

   property p_badtrk;
      @(posedge clk) disable iff (!reset_n)
      statusThird[FRSE_B2_BAD_TRK] |-> statusThird[FRSE_B2_TRK_MISM];
   endproperty
   a_badtrk: assert property (p_badtrk) else $error("Bad track without mismatch.");

   property p_crc_data;
      @(posedge clk) disable iff (!reset_n)
      statusThird[FRSE_B2_CRC_DATA] |-> statusSecond[FRSE_B1_CRC_ANY];
   endproperty
   a_crc_data: assert property (p_crc_data) else $error("Data CRC without any CRC.");

   sequence s_start;
      state_q == FRSE_IDLE && cmdStart;
   endsequence
   property p_clear;
      @(posedge clk) disable iff (!reset_n)
      s_start |=> ##1 statusSecond[7] == 1'b0 && statusThird == FRSE_BYTE_RESET;
   endproperty
   a_clear: assert property (p_clear) else $error("Flags not cleared at start.");

   property p_dir;
      @(posedge clk) disable iff (!reset_n)
      transferDirection |-> hostServiceRequest;
   endproperty
   a_dir: assert property (p_dir) else $error("Direction without request.");

endmodule

// file: logic/frse_pkg.sv
// Package holding constants and types of the floppy result status encoder.
// Behaviour
// - Completion code 00 on clean finish.
// - Completion code 01 when execution failed.
// - Completion code 10 for invalid command.
// - Completion code 11 for polling termination.
// - Positioning finished bit five after seeks.
// - Equipment fault after 255 steps without track zero.
// - Equipment fault on relative seek past zero.
// - Side bit two, drive bits one-zero.
// - Unused status bits always read zero.
// - Sector beyond track end sets bit seven.
// - Any CRC fault sets second byte bit five.
// - Overrun or underrun sets bit four.
// - Sector absent cases set bit two.
// - Write protect during write sets bit one.
// - Missing address marks set bit zero.
// - Wrong data mark kind sets bit six.
// - Data field CRC sets third bit five.
// - Track mismatch sets third byte bit four.
// - Mismatch with track FF sets bit one.
// - Missing data mark sets third bit zero.
// - Status bytes read through data register.
package frse_pkg;

   // -----------------------------------------------------------------
   // Field positions and values
   // -----------------------------------------------------------------
   localparam logic [1:0] FRSE_CC_NORMAL   = 2'h0;
   localparam logic [1:0] FRSE_CC_ABNORMAL = 2'h1;
   localparam logic [1:0] FRSE_CC_INVALID  = 2'h2;
   localparam logic [1:0] FRSE_CC_POLLING  = 2'h3;
   localparam int         FRSE_B0_POS_DONE = 5;
   localparam int         FRSE_B0_EQ_FAULT = 4;
   localparam int         FRSE_B1_END_TRK  = 7;
   localparam int         FRSE_B1_CRC_ANY  = 5;
   localparam int         FRSE_B1_OVERRUN  = 4;
   localparam int         FRSE_B1_ABSENT   = 2;
   localparam int         FRSE_B1_WPROT    = 1;
   localparam int         FRSE_B1_MISS_ID  = 0;
   localparam int         FRSE_B2_CTL_MARK = 6;
   localparam int         FRSE_B2_CRC_DATA = 5;
   localparam int         FRSE_B2_TRK_MISM = 4;
   localparam int         FRSE_B2_BAD_TRK  = 1;
   localparam int         FRSE_B2_MISS_DAT = 0;
   localparam logic [7:0] FRSE_BAD_TRACK   = 8'hFF;
   localparam logic [7:0] FRSE_RECAL_STEPS = 8'hFF;
   localparam logic [1:0] FRSE_INDEX_LIMIT = 2'h2;
   localparam logic [7:0] FRSE_BYTE_RESET  = 8'h00;
   localparam logic [1:0] FRSE_IDX_FIRST   = 2'h0;
   localparam logic [1:0] FRSE_IDX_LAST    = 2'h2;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   // Error events reported by the command engine, one-cycle pulses.
   typedef struct packed {
      logic       sectorPastEnd;
      logic       idCrcFault;
      logic       dataCrcFault;
      logic       overrun;
      logic       sectorNotFound;
      logic       readIdFault;
      logic       trackSeqFault;
      logic       idMarkSeen;
      logic       dataMarkMissing;
      logic       deletedMarkSeen;
      logic       normalMarkSeen;
      logic       idTrackValid;
      logic [7:0] idTrack;
   } frse_event_t;

   // Command context held by the command engine while it runs.
   typedef struct packed {
      logic       readData;
      logic       readDeleted;
      logic       writeCmd;
      logic       seekCmd;
      logic       relSeekOutPastZero;
      logic       recalibrate;
      logic       stepPulse;
      logic       side;
      logic [1:0] drive;
      logic [7:0] curTrack;
   } frse_ctx_t;

   typedef enum logic [3:0] {
      FRSE_IDLE   = 4'b0001,
      FRSE_EXEC   = 4'b0010,
      FRSE_RESULT = 4'b0100,
      FRSE_DONE   = 4'b1000
   } frse_state_t;

endpackage

// file: logic/frse_step_watch.sv
// Step counter that flags recalibrate failure after 255 steps.
`timescale 1ns/1ps
module frse_step_watch
   import frse_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic start,
   input  wire logic recal,
   input  wire logic stepPulse,
   input  wire logic trackZero,
   output logic      fault
);

   logic [7:0] steps_q;

   // -----------------------------------------------------------------
   // Step counting
   // -----------------------------------------------------------------
   // Counting saturates so a stuck drive never wraps back to a pass.
   always_ff @(posedge clk) begin
      if (!reset_n || start || trackZero) begin
         steps_q <= 8'h00;
      end else if (recal && stepPulse && steps_q != FRSE_RECAL_STEPS) begin
         steps_q <= steps_q + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || start) begin
         fault <= 1'b0;
      end else if (recal && !trackZero && steps_q == FRSE_RECAL_STEPS) begin
         fault <= 1'b1;
      end
   end

endmodule

// file: logic/frse_index_watch.sv
// Index pulse counter that flags a missing identifier mark.
`timescale 1ns/1ps
module frse_index_watch
   import frse_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic start,
   input  wire logic searching,
   input  wire logic indexPulse,
   input  wire logic idMarkSeen,
   output logic      missing
);

   logic [1:0] idx_q;

   // -----------------------------------------------------------------
   // Index counting
   // -----------------------------------------------------------------
   // A seen mark restarts the count; two revolutions without one fail.
   always_ff @(posedge clk) begin
      if (!reset_n || start || idMarkSeen || !searching) begin
         idx_q <= FRSE_IDX_FIRST;
      end else if (indexPulse && idx_q != FRSE_IDX_LAST) begin
         idx_q <= idx_q + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || start) begin
         missing <= 1'b0;
      end else if (searching && indexPulse && idx_q == FRSE_INDEX_LIMIT - 2'h1) begin
         missing <= 1'b1;
      end
   end

endmodule

// file: tb/frse_host_model.sv
// Host model that fetches the three result bytes through the data register.
`timescale 1ns/1ps
module frse_host_model
   import frse_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       fetch,
   input  wire logic       hostServiceRequest,
   input  wire logic       transferDirection,
   input  wire logic [7:0] dataOut,
   output logic            dataRead,
   output logic [2:0][7:0] resBytes,
   output logic            busy,
   output logic            fetchFail
);
   // Each byte waits a bounded time for the flags, then holds one read strobe.
   // The gap after each read lets the byte pointer settle before the next one.
   initial begin
      int n;
      dataRead = 1'b0;
      resBytes = '0;
      busy = 1'b0;
      fetchFail = 1'b0;
      forever begin
         @(posedge clk);
         if (fetch === 1'b1) begin
            busy <= 1'b1;
            for (int i = 0; i < 3; i++) begin
               n = 0;
               while (!(hostServiceRequest === 1'b1 && transferDirection === 1'b1) && n < 64) begin
                  @(posedge clk);
                  n++;
               end
               if (n >= 64) begin
                  fetchFail <= 1'b1;
               end
               dataRead <= 1'b1;
               @(posedge clk);
               resBytes[i] <= dataOut;
               dataRead <= 1'b0;
               repeat (2) @(posedge clk);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule

// file: tb/frse_encoder_tb.sv
// Self-checking testbench of the floppy result status encoder.
`timescale 1ns/1ps
module frse_encoder_tb;
   import frse_pkg::*;
   logic clk, reset_n, cmdStart, cmdInvalid, cmdEnd, pollAbort, positionDone, returnsStatus;
   logic trackZeroInput, writeProtectInput, rotationMarkerInput, transferEndStrobe, dataRead;
   logic fetch, busy, fetchFail;
   logic [7:0] dataOut, statusFirst, statusSecond, statusThird;
   logic [2:0][7:0] resBytes;
   logic hostServiceRequest, transferDirection;
   frse_ctx_t ctx;
   frse_event_t evt;
   int n_mismatch, checked, cycles;

   frse_encoder u_dut (.clk(clk), .reset_n(reset_n), .cmdStart(cmdStart), .cmdInvalid(cmdInvalid),
      .cmdEnd(cmdEnd), .pollAbort(pollAbort), .positionDone(positionDone), .returnsStatus(returnsStatus),
      .ctx(ctx), .evt(evt), .trackZeroInput(trackZeroInput), .writeProtectInput(writeProtectInput),
      .rotationMarkerInput(rotationMarkerInput), .transferEndStrobe(transferEndStrobe), .dataRead(dataRead),
      .dataOut(dataOut), .hostServiceRequest(hostServiceRequest), .transferDirection(transferDirection),
      .statusFirst(statusFirst), .statusSecond(statusSecond), .statusThird(statusThird));
   frse_host_model u_host (.clk(clk), .fetch(fetch), .hostServiceRequest(hostServiceRequest),
      .transferDirection(transferDirection), .dataOut(dataOut), .dataRead(dataRead), .resBytes(resBytes),
      .busy(busy), .fetchFail(fetchFail));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic stop_test();
      if (n_mismatch == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic start_cmd(input frse_ctx_t c, input logic inv);
      ctx <= c;
      cmdInvalid <= inv;
      cmdStart <= 1'b1;
      @(posedge clk);
      cmdStart <= 1'b0;
      cmdInvalid <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse_evt(input frse_event_t e);
      evt <= e;
      @(posedge clk);
      evt <= '0;
      @(posedge clk);
   endtask

   task automatic end_cmd(input logic tc, input logic poll);
      transferEndStrobe <= tc;
      cmdEnd <= 1'b1;
      pollAbort <= poll;
      @(posedge clk);
      cmdEnd <= 1'b0;
      pollAbort <= 1'b0;
   endtask

   // Reads via the host model and compares both the read bytes and the copies.
   task automatic fetch_chk(input logic [7:0] x0, input logic [7:0] m0, input logic [7:0] x1,
                            input logic [7:0] x2);
      int n;
      fetch <= 1'b1;
      @(posedge clk);
      fetch <= 1'b0;
      @(posedge clk);
      for (n = 0; busy === 1'b1 && n < 400; n++) @(posedge clk);
      chk({7'h00, fetchFail | busy}, 8'h00);
      chk(resBytes[0] & m0, x0 & m0);
      chk(resBytes[1], x1);
      chk(resBytes[2], x2);
      chk(statusFirst & m0, x0 & m0);
      chk(statusSecond, x1);
      chk(statusThird, x2);
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_codes();
      frse_ctx_t c;
      frse_event_t e;
      for (int i = 0; i < 5; i++) begin
         c = '0;
         e = '0;
         c.readData = 1'b1;
         c.side = 1'b1;
         c.drive = 2'h2;
         if (i == 4) begin
            start_cmd(c, 1'b1);
            fetch_chk({FRSE_CC_INVALID, 6'h00}, 8'hC8, 8'h00, 8'h00);
         end else begin
            e.overrun = (i == 1);
            e.dataCrcFault = (i == 1);
            start_cmd(c, 1'b0);
            pulse_evt(e);
            end_cmd(i != 2, i == 3);
            case (i)
               0: fetch_chk(8'h06, 8'hFF, 8'h00, 8'h00);
               1: fetch_chk(8'h46, 8'hFF, 8'h30, 8'h20);
               2: fetch_chk(8'h46, 8'hFF, 8'h80, 8'h00);
               default: fetch_chk(8'hC6, 8'hFF, 8'h00, 8'h00);
            endcase
         end
      end
   endtask

   task automatic t_events();
      frse_ctx_t c;
      frse_event_t e;
      logic [7:0] x1, x2, m;
      logic [1:0] cc;
      for (int i = 0; i < 10; i++) begin
         c = '0;
         e = '0;
         c.readData = 1'b1;
         c.drive = i[1:0];
         c.curTrack = 8'h03;
         x1 = 8'h00;
         x2 = 8'h00;
         m = 8'hFF;
         cc = FRSE_CC_ABNORMAL;
         case (i)
            0: begin e.sectorNotFound = 1'b1; x1 = 8'h04; end
            1: begin e.readIdFault = 1'b1; x1 = 8'h04; end
            2: begin e.trackSeqFault = 1'b1; x1 = 8'h04; end
            3: begin e.dataMarkMissing = 1'b1; x1 = 8'h01; x2 = 8'h01; end
            4: begin e.deletedMarkSeen = 1'b1; x2 = 8'h40; m = 8'h3F; end
            5: begin c.readData = 1'b0; c.readDeleted = 1'b1; e.normalMarkSeen = 1'b1; x2 = 8'h40; m = 8'h3F; end
            6: begin e.idTrackValid = 1'b1; e.idTrack = 8'h05; x2 = 8'h10; end
            7: begin e.idTrackValid = 1'b1; e.idTrack = FRSE_BAD_TRACK; x2 = 8'h12; end
            8: begin e.idTrackValid = 1'b1; e.idTrack = 8'h03; cc = FRSE_CC_NORMAL; end
            default: begin e.idCrcFault = 1'b1; x1 = 8'h20; end
         endcase
         start_cmd(c, 1'b0);
         pulse_evt(e);
         end_cmd(1'b1, 1'b0);
         fetch_chk({cc, 4'h0, c.drive}, m, x1, x2);
      end
   endtask

   task automatic t_drive_inputs();
      frse_ctx_t c;
      c = '0;
      c.writeCmd = 1'b1;
      start_cmd(c, 1'b0);
      writeProtectInput <= 1'b1;
      repeat (3) @(posedge clk);
      writeProtectInput <= 1'b0;
      end_cmd(1'b1, 1'b0);
      fetch_chk(8'h40, 8'hFF, 8'h02, 8'h00);
      c = '0;
      c.readData = 1'b1;
      start_cmd(c, 1'b0);
      repeat (2) begin
         rotationMarkerInput <= 1'b1;
         @(posedge clk);
         rotationMarkerInput <= 1'b0;
         repeat (4) @(posedge clk);
      end
      end_cmd(1'b1, 1'b0);
      fetch_chk(8'h40, 8'hFF, 8'h01, 8'h00);
   endtask

   // Step count boundary: 254 steps then track zero passes, 255 without it fails.
   task automatic t_position(input int steps, input logic rel);
      frse_ctx_t c;
      c = '0;
      c.recalibrate = !rel;
      c.seekCmd = rel;
      c.relSeekOutPastZero = rel;
      c.drive = 2'h1;
      start_cmd(c, 1'b0);
      for (int k = 0; k < steps; k++) begin
         ctx.stepPulse <= 1'b1;
         @(posedge clk);
         ctx.stepPulse <= 1'b0;
         @(posedge clk);
      end
      trackZeroInput <= (steps == 254);
      positionDone <= 1'b1;
      @(posedge clk);
      positionDone <= 1'b0;
      @(posedge clk);
      end_cmd(1'b1, 1'b0);
      trackZeroInput <= 1'b0;
      fetch_chk((steps == 254) ? 8'h21 : 8'h31, 8'h3F, 8'h00, 8'h00);
   endtask

   // A command without status must skip the result phase and fall back to idle.
   task automatic t_no_result();
      frse_ctx_t c;
      c = '0;
      c.seekCmd = 1'b1;
      returnsStatus <= 1'b0;
      start_cmd(c, 1'b0);
      end_cmd(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      chk({6'h00, hostServiceRequest, transferDirection}, 8'h02);
      returnsStatus <= 1'b1;
   endtask

   // -----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // A hang past the expected run length counts as a mismatch.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         stop_test();
      end
   end

   initial begin
      {reset_n, cmdStart, cmdInvalid, cmdEnd, pollAbort, positionDone} = '0;
      {trackZeroInput, writeProtectInput, rotationMarkerInput, transferEndStrobe, fetch} = '0;
      returnsStatus = 1'b1;
      ctx = '0;
      evt = '0;
      n_mismatch = 0;
      checked = 0;
      cycles = 0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_codes();
      t_events();
      t_drive_inputs();
      t_position(254, 1'b0);
      t_position(255, 1'b0);
      t_position(0, 1'b1);
      t_no_result();
      stop_test();
   end
endmodule
